//--- hw/cit_timing_map.svh
`ifndef CIT_TIMING_MAP_SVH
`define CIT_TIMING_MAP_SVH

// ****************************************
// widths
// ****************************************
`define CIT_LEN_W 2
`define CIT_CYC_W 3
`define CIT_CLK_CNT_W 32

// ****************************************
// opcode patterns
// ****************************************
`define CIT_OP_INC_WREG_HI 5'h01
`define CIT_OP_SUB_WREG_HI 5'h13
`define CIT_OP_DECJ_WREG_HI 5'h1b
`define CIT_OP_CMPJ_HI 4'hb
`define CIT_OP_INC_PTR 8'ha3
`define CIT_OP_DECJ_DIR 8'hd5
`define CIT_OP_CMPJ_FIRST 8'hb4
`define CIT_OP_XMOV_RD_PTR 8'he0
`define CIT_OP_XMOV_RD_IND_HI 7'h71
`define CIT_OP_XMOV_WR_PTR 8'hf0
`define CIT_OP_XMOV_WR_IND_HI 7'h79

// ****************************************
// timing and reset values
// ****************************************
`define CIT_TAKEN_EXTRA 3'h1
`define CIT_PSTORE_RST 1'b0
`define CIT_BYTE_RST 8'h00
`define CIT_PTR_RST 16'h0000

`endif

//--- hw/cit_pkg.sv
package cit_pkg;

   typedef enum logic [2:0] {
      CIT_K_PLAIN,
      CIT_K_INC_WREG,
      CIT_K_SUB_WREG,
      CIT_K_INC_PTR,
      CIT_K_XMOV_RD,
      CIT_K_XMOV_WR,
      CIT_K_CBRANCH
   } cit_kind_t;

   typedef enum logic {
      CIT_S_IDLE,
      CIT_S_BUSY
   } cit_state_t;

endpackage

//--- hw/cit_dec_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "cit_timing_map.svh"

interface cit_dec_if;
   logic [7:0] opcode;
   logic [`CIT_LEN_W-1:0] len;
   cit_pkg::cit_kind_t kind;

   modport dec (input opcode, output len, output kind);
   modport core (output opcode, input len, input kind);
endinterface

`default_nettype wire

//--- hw/cit_opcode_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "cit_timing_map.svh"

module cit_opcode_decode (
   cit_dec_if.dec dec
);

   // ****************************************
   // byte length of every opcode
   // ****************************************
   function automatic logic [`CIT_LEN_W-1:0] cit_len(input logic [7:0] op);
      logic [3:0] hi;
      hi = op[7:4];
      cit_len = 2'h1;
      unique case (op[3:0])
         4'h0: cit_len = (hi == 4'h0 || hi >= 4'he) ? 2'h1 :
                         (hi inside {4'h1, 4'h2, 4'h3, 4'h9}) ? 2'h3 : 2'h2;
         4'h1: cit_len = 2'h2;
         4'h2: cit_len = (hi <= 4'h1) ? 2'h3 :
                         (hi inside {4'h2, 4'h3, 4'he, 4'hf}) ? 2'h1 : 2'h2;
         4'h3: cit_len = (hi inside {4'h4, 4'h5, 4'h6}) ? 2'h3 : 2'h1;
         4'h4: cit_len = (hi == 4'hb) ? 2'h3 :
                         (hi <= 4'h1 || hi == 4'h8 || hi >= 4'ha) ? 2'h1 : 2'h2;
         4'h5: cit_len = (hi inside {4'h7, 4'h8, 4'hb, 4'hd}) ? 2'h3 : 2'h2;
         4'h6, 4'h7: cit_len = (hi == 4'hb) ? 2'h3 :
                         (hi inside {4'h7, 4'h8, 4'ha}) ? 2'h2 : 2'h1;
         default: cit_len = (hi == 4'hb) ? 2'h3 :
                         (hi inside {4'h7, 4'h8, 4'ha, 4'hd}) ? 2'h2 : 2'h1;
      endcase
   endfunction

   // ****************************************
   // instruction class
   // ****************************************
   function automatic cit_pkg::cit_kind_t cit_kind(input logic [7:0] op);
      logic cbr;
      cbr = (op[3:0] == 4'h0 && op[7:4] >= 4'h1 && op[7:4] <= 4'h7) ||
            (op[7:4] == `CIT_OP_CMPJ_HI && op >= `CIT_OP_CMPJ_FIRST) ||
            (op == `CIT_OP_DECJ_DIR) || (op[7:3] == `CIT_OP_DECJ_WREG_HI);
      if (op[7:3] == `CIT_OP_INC_WREG_HI) begin
         cit_kind = cit_pkg::CIT_K_INC_WREG;
      end else if (op[7:3] == `CIT_OP_SUB_WREG_HI) begin
         cit_kind = cit_pkg::CIT_K_SUB_WREG;
      end else if (op == `CIT_OP_INC_PTR) begin
         cit_kind = cit_pkg::CIT_K_INC_PTR;
      end else if (op == `CIT_OP_XMOV_RD_PTR || op[7:1] == `CIT_OP_XMOV_RD_IND_HI) begin
         cit_kind = cit_pkg::CIT_K_XMOV_RD;
      end else if (op == `CIT_OP_XMOV_WR_PTR || op[7:1] == `CIT_OP_XMOV_WR_IND_HI) begin
         cit_kind = cit_pkg::CIT_K_XMOV_WR;
      end else if (cbr) begin
         cit_kind = cit_pkg::CIT_K_CBRANCH;
      end else begin
         cit_kind = cit_pkg::CIT_K_PLAIN;
      end
   endfunction

   assign dec.len = cit_len(dec.opcode);
   assign dec.kind = cit_kind(dec.opcode);

endmodule

`default_nettype wire

//--- hw/cit_core_timing.sv
// Contract
// - execution time is counted in plain clock cycles, no machine-cycle grouping.
// - most instructions take as many clocks as they have program bytes.
// - a conditional branch not taken finishes one clock before a taken one.
// - external-data moves reach flash program space when program store is selected.
// - external-data moves reach external data RAM when external space is selected.
// - increment working register is one byte and one clock.
// - subtract with borrow from a working register is one byte and one clock.
// - 16-bit data pointer increment is one byte and one clock.
`timescale 1ns/10ps
`default_nettype none
`include "cit_timing_map.svh"

module cit_core_timing #(
   parameter int NUM_WREG = 8
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic issue_valid_i,
   input wire logic [7:0] issue_opcode_i,
   input wire logic branch_taken_i,
   input wire logic pstore_wr_i,
   input wire logic pstore_sel_i,
   input wire logic [7:0] xmem_rdata_i,
   input wire logic xmem_rvalid_i,
   output logic issue_ready_o,
   output logic retire_o,
   output logic [`CIT_CYC_W-1:0] retire_cycles_o,
   output logic [`CIT_CLK_CNT_W-1:0] exec_clocks_o,
   output logic xmem_req_o,
   output logic xmem_we_o,
   output logic xmem_flash_sel_o,
   output logic [15:0] xmem_addr_o,
   output logic [7:0] xmem_wdata_o,
   output logic program_store_control_o,
   output logic [7:0] acc_o,
   output logic carry_o,
   output logic [15:0] data_pointer_16bit_o
);

   // ****************************************
   // decode
   // ****************************************
   cit_dec_if dec_bus ();

   cit_opcode_decode u_dec (
      .dec(dec_bus)
   );

   assign dec_bus.opcode = issue_opcode_i;

   cit_pkg::cit_state_t state_q;
   logic [`CIT_CYC_W-1:0] cnt_q;
   logic ready_q;
   logic retire_q;
   logic [`CIT_CYC_W-1:0] retire_cycles_q;
   logic [`CIT_CYC_W-1:0] cur_cycles_q;
   logic [`CIT_CLK_CNT_W-1:0] clk_cnt_q;
   logic accept;
   logic [`CIT_CYC_W-1:0] cycles_d;

   assign accept = issue_valid_i && ready_q;

   // ****************************************
   // cycle cost of the offered instruction
   // ****************************************
   always_comb begin
      cycles_d = {1'b0, dec_bus.len};
      if (dec_bus.kind == cit_pkg::CIT_K_CBRANCH && branch_taken_i) begin
         cycles_d = {1'b0, dec_bus.len} + `CIT_TAKEN_EXTRA;
      end
   end

   // ****************************************
   // execution sequencer
   // ****************************************
   // counts whole clocks only; each cycle of an instruction is one clk_i edge
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= cit_pkg::CIT_S_IDLE;
         cnt_q <= '0;
         ready_q <= 1'b1;
         cur_cycles_q <= '0;
      end else begin
         unique case (state_q)
            cit_pkg::CIT_S_IDLE: begin
               if (accept && cycles_d != 3'h1) begin
                  state_q <= cit_pkg::CIT_S_BUSY;
                  cnt_q <= cycles_d - 3'h1;
                  ready_q <= 1'b0;
                  cur_cycles_q <= cycles_d;
               end
            end
            cit_pkg::CIT_S_BUSY: begin
               cnt_q <= cnt_q - 3'h1;
               if (cnt_q == 3'h1) begin
                  state_q <= cit_pkg::CIT_S_IDLE;
                  ready_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // ****************************************
   // retire report
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         retire_q <= 1'b0;
         retire_cycles_q <= '0;
      end else if (accept && cycles_d == 3'h1) begin
         retire_q <= 1'b1;
         retire_cycles_q <= cycles_d;
      end else if (state_q == cit_pkg::CIT_S_BUSY && cnt_q == 3'h1) begin
         retire_q <= 1'b1;
         retire_cycles_q <= cur_cycles_q;
      end else begin
         retire_q <= 1'b0;
      end
   end

   // running total of execution clocks; wraps silently
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         clk_cnt_q <= '0;
      end else if (accept || state_q == cit_pkg::CIT_S_BUSY) begin
         clk_cnt_q <= clk_cnt_q + 32'h1;
      end
   end

   // ****************************************
   // program store control
   // ****************************************
   logic pstore_q;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pstore_q <= `CIT_PSTORE_RST;
      end else if (pstore_wr_i) begin
         pstore_q <= pstore_sel_i;
      end
   end

   // ****************************************
   // one-clock datapath
   // ****************************************
   logic [7:0] wreg_q [NUM_WREG];
   logic [7:0] acc_q;
   logic carry_q;
   logic [15:0] ptr_q;
   logic [2:0] rsel;
   logic [8:0] sub_res;

   assign rsel = issue_opcode_i[2:0];
   assign sub_res = {1'b0, acc_q} - {1'b0, wreg_q[rsel]} - {8'h00, carry_q};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_WREG; gi++) begin : g_wreg
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               wreg_q[gi] <= `CIT_BYTE_RST;
            end else if (accept && dec_bus.kind == cit_pkg::CIT_K_INC_WREG
                         && rsel == 3'(gi)) begin
               wreg_q[gi] <= wreg_q[gi] + 8'h01;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         acc_q <= `CIT_BYTE_RST;
         carry_q <= 1'b0;
      end else if (xmem_rvalid_i) begin
         acc_q <= xmem_rdata_i;
      end else if (accept && dec_bus.kind == cit_pkg::CIT_K_SUB_WREG) begin
         acc_q <= sub_res[7:0];
         carry_q <= sub_res[8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ptr_q <= `CIT_PTR_RST;
      end else if (accept && dec_bus.kind == cit_pkg::CIT_K_INC_PTR) begin
         ptr_q <= ptr_q + 16'h0001;
      end
   end

   // ****************************************
   // external-data move steering
   // ****************************************
   // target chosen at issue, so a later control write cannot redirect it
   logic xreq_q;
   logic xwe_q;
   logic xflash_q;
   logic [15:0] xaddr_q;
   logic [7:0] xwdata_q;
   logic is_xmov;

   assign is_xmov = dec_bus.kind == cit_pkg::CIT_K_XMOV_RD ||
                    dec_bus.kind == cit_pkg::CIT_K_XMOV_WR;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         xreq_q <= 1'b0;
         xwe_q <= 1'b0;
         xflash_q <= `CIT_PSTORE_RST;
         xaddr_q <= '0;
         xwdata_q <= '0;
      end else if (accept && is_xmov) begin
         xreq_q <= 1'b1;
         xwe_q <= dec_bus.kind == cit_pkg::CIT_K_XMOV_WR;
         xflash_q <= pstore_q;
         xaddr_q <= issue_opcode_i[1] ? {8'h00, wreg_q[{2'b00, issue_opcode_i[0]}]} : ptr_q;
         xwdata_q <= acc_q;
      end else begin
         xreq_q <= 1'b0;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign issue_ready_o = ready_q;
   assign retire_o = retire_q;
   assign retire_cycles_o = retire_cycles_q;
   assign exec_clocks_o = clk_cnt_q;
   assign xmem_req_o = xreq_q;
   assign xmem_we_o = xwe_q;
   assign xmem_flash_sel_o = xflash_q;
   assign xmem_addr_o = xaddr_q;
   assign xmem_wdata_o = xwdata_q;
   assign program_store_control_o = pstore_q;
   assign acc_o = acc_q;
   assign carry_o = carry_q;
   assign data_pointer_16bit_o = ptr_q;

endmodule

`default_nettype wire

//--- test/cit_core_timing_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "cit_timing_map.svh"
module cit_core_timing_asserts (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic issue_valid_i,
   input wire logic [7:0] issue_opcode_i,
   input wire logic branch_taken_i,
   input wire logic pstore_wr_i,
   input wire logic pstore_sel_i,
   input wire logic issue_ready_o,
   input wire logic retire_o,
   input wire logic [`CIT_CYC_W-1:0] retire_cycles_o,
   input wire logic xmem_req_o,
   input wire logic xmem_we_o,
   input wire logic xmem_flash_sel_o,
   input wire logic program_store_control_o,
   input wire logic [15:0] data_pointer_16bit_o
);
   // ****************************************
   // accepted instruction
   // ****************************************
   logic take_w;
   assign take_w = issue_valid_i && issue_ready_o;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_rst;
      $fell(sys_rst_i) |-> issue_ready_o && !retire_o && !program_store_control_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_pstore;
      pstore_wr_i |=> program_store_control_o == $past(pstore_sel_i);
   endproperty
   a_pstore: assert property (p_pstore) else $error("store select not taken");
   property p_inc;
      take_w && issue_opcode_i[7:3] == `CIT_OP_INC_WREG_HI |=> retire_o && retire_cycles_o == 3'h1;
   endproperty
   a_inc: assert property (p_inc) else $error("inc register not one clock");
   property p_sub;
      take_w && issue_opcode_i[7:3] == `CIT_OP_SUB_WREG_HI |=> retire_o && retire_cycles_o == 3'h1;
   endproperty
   a_sub: assert property (p_sub) else $error("subtract not one clock");
   property p_ptr;
      take_w && issue_opcode_i == `CIT_OP_INC_PTR |=>
         retire_o && data_pointer_16bit_o == $past(data_pointer_16bit_o) + 16'h0001;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer increment wrong");
   property p_two;
      take_w && issue_opcode_i == 8'h74 |=> !issue_ready_o ##1 retire_o && retire_cycles_o == 3'h2;
   endproperty
   a_two: assert property (p_two) else $error("two byte op not two clocks");
   property p_brt;
      take_w && issue_opcode_i == 8'h60 && branch_taken_i |=>
         !retire_o [*2] ##1 retire_o && retire_cycles_o == 3'h3;
   endproperty
   a_brt: assert property (p_brt) else $error("taken branch timing wrong");
   property p_brn;
      take_w && issue_opcode_i == 8'h60 && !branch_taken_i |=>
         !retire_o ##1 retire_o && retire_cycles_o == 3'h2;
   endproperty
   a_brn: assert property (p_brn) else $error("untaken branch timing wrong");
   property p_xmov;
      take_w && issue_opcode_i == `CIT_OP_XMOV_WR_PTR |=>
         xmem_req_o && xmem_we_o && xmem_flash_sel_o == $past(program_store_control_o);
   endproperty
   a_xmov: assert property (p_xmov) else $error("move space wrong");
endmodule

bind cit_core_timing cit_core_timing_asserts u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .issue_valid_i(issue_valid_i), .issue_opcode_i(issue_opcode_i),
   .branch_taken_i(branch_taken_i), .pstore_wr_i(pstore_wr_i), .pstore_sel_i(pstore_sel_i),
   .issue_ready_o(issue_ready_o), .retire_o(retire_o), .retire_cycles_o(retire_cycles_o),
   .xmem_req_o(xmem_req_o), .xmem_we_o(xmem_we_o), .xmem_flash_sel_o(xmem_flash_sel_o),
   .program_store_control_o(program_store_control_o),
   .data_pointer_16bit_o(data_pointer_16bit_o));
`default_nettype wire

//--- test/test_cit_core_timing.sv
`timescale 1ns/10ps
`default_nettype none
`include "cit_timing_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_cit_core_timing;
   logic clk_i = 0, sys_rst_i = 1, issue_valid_i = 0, branch_taken_i = 0;
   logic pstore_wr_i = 0, pstore_sel_i = 0, xmem_rvalid_i = 0;
   logic [7:0] issue_opcode_i = 8'h00, xmem_rdata_i = 8'h00;
   logic issue_ready_o, retire_o, xmem_req_o, xmem_we_o, xmem_flash_sel_o;
   logic program_store_control_o, carry_o;
   logic [`CIT_CYC_W-1:0] retire_cycles_o;
   logic [7:0] xmem_wdata_o, acc_o;
   logic [15:0] xmem_addr_o, data_pointer_16bit_o;
   logic [`CIT_CLK_CNT_W-1:0] exec_clocks_o;
   int miscompares = 0, checks_done = 0;
   int n;
   always #2.5 clk_i = ~clk_i;
   cit_core_timing dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .issue_valid_i(issue_valid_i),
      .issue_opcode_i(issue_opcode_i), .branch_taken_i(branch_taken_i),
      .pstore_wr_i(pstore_wr_i), .pstore_sel_i(pstore_sel_i), .xmem_rdata_i(xmem_rdata_i),
      .xmem_rvalid_i(xmem_rvalid_i), .issue_ready_o(issue_ready_o), .retire_o(retire_o),
      .retire_cycles_o(retire_cycles_o), .exec_clocks_o(exec_clocks_o),
      .xmem_req_o(xmem_req_o),
      .xmem_we_o(xmem_we_o), .xmem_flash_sel_o(xmem_flash_sel_o), .xmem_addr_o(xmem_addr_o),
      .xmem_wdata_o(xmem_wdata_o), .program_store_control_o(program_store_control_o),
      .acc_o(acc_o), .carry_o(carry_o), .data_pointer_16bit_o(data_pointer_16bit_o));
   // ****************************************
   // helpers
   // ****************************************
   // counts clocks from the taking edge to the retire pulse, capped at 9
   task automatic run(input logic [7:0] op, input logic tk, output int c);
      @(negedge clk_i);
      issue_valid_i = 1;
      issue_opcode_i = op;
      branch_taken_i = tk;
      @(negedge clk_i);
      issue_valid_i = 0;
      c = 1;
      while (retire_o !== 1'b1 && c < 9) begin
         @(negedge clk_i);
         c++;
      end
   endtask
   task automatic set_store(input logic v);
      @(negedge clk_i);
      pstore_wr_i = 1;
      pstore_sel_i = v;
      @(negedge clk_i);
      pstore_wr_i = 0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      `CHK("ready", 1'b1, issue_ready_o)
      `CHK("store sel", 1'b0, program_store_control_o)
      `CHK("pointer", 16'h0000, data_pointer_16bit_o)
      `CHK("exec clocks", 0, exec_clocks_o)
      $display("test reset done");
   endtask
   task automatic t_alu;
      run(8'h09, 1'b0, n);
      `CHK("inc clocks", 1, n)
      `CHK("inc count", 3'h1, retire_cycles_o)
      run(8'h99, 1'b0, n);
      `CHK("sub clocks", 1, n)
      `CHK("sub acc", 8'hff, acc_o)
      `CHK("sub borrow", 1'b1, carry_o)
      run(8'h9a, 1'b0, n);
      `CHK("sub acc2", 8'hfe, acc_o)
      `CHK("sub borrow2", 1'b0, carry_o)
      $display("test alu done");
   endtask
   task automatic t_ptr;
      run(8'ha3, 1'b0, n);
      `CHK("pointer clocks", 1, n)
      run(8'ha3, 1'b0, n);
      `CHK("pointer value", 16'h0002, data_pointer_16bit_o)
      $display("test pointer done");
   endtask
   task automatic t_timing;
      logic [7:0] ops[8] = '{8'h74, 8'h85, 8'h60, 8'h60, 8'hd8, 8'hd8, 8'hb4, 8'hb4};
      logic tks[8] = '{0, 0, 1, 0, 1, 0, 1, 0};
      int exp[8] = '{2, 3, 3, 2, 3, 2, 4, 3};
      logic [`CIT_CLK_CNT_W-1:0] base;
      for (int i = 0; i < 8; i++) begin
         base = exec_clocks_o;
         run(ops[i], tks[i], n);
         `CHK("clocks", exp[i], n)
         `CHK("count", exp[i][2:0], retire_cycles_o)
         `CHK("exec clocks", exp[i], exec_clocks_o - base)
      end
      $display("test timing done");
   endtask
   task automatic t_xmov;
      run(8'hf0, 1'b0, n);
      `CHK("req", 1'b1, xmem_req_o)
      `CHK("we", 1'b1, xmem_we_o)
      `CHK("xram sel", 1'b0, xmem_flash_sel_o)
      `CHK("addr", 16'h0002, xmem_addr_o)
      `CHK("wdata", 8'hfe, xmem_wdata_o)
      set_store(1'b1);
      `CHK("store sel", 1'b1, program_store_control_o)
      run(8'he0, 1'b0, n);
      `CHK("rd we", 1'b0, xmem_we_o)
      `CHK("flash sel", 1'b1, xmem_flash_sel_o)
      @(negedge clk_i);
      xmem_rdata_i = 8'h5a;
      xmem_rvalid_i = 1;
      @(negedge clk_i);
      xmem_rvalid_i = 0;
      `CHK("rd acc", 8'h5a, acc_o)
      set_store(1'b0);
      run(8'hf0, 1'b0, n);
      `CHK("xram again", 1'b0, xmem_flash_sel_o)
      run(8'hf3, 1'b0, n);
      `CHK("ind addr", 16'h0001, xmem_addr_o)
      `CHK("ind xram sel", 1'b0, xmem_flash_sel_o)
      `CHK("ind wdata", 8'h5a, xmem_wdata_o)
      $display("test xmove done");
   endtask
   task automatic t_mid_reset;
      set_store(1'b1);
      `CHK("mid store set", 1'b1, program_store_control_o)
      @(negedge clk_i);
      sys_rst_i = 1;
      @(negedge clk_i);
      sys_rst_i = 0;
      `CHK("mid store sel", 1'b0, program_store_control_o)
      `CHK("mid ready", 1'b1, issue_ready_o)
      `CHK("mid pointer", 16'h0000, data_pointer_16bit_o)
      `CHK("mid clocks", 0, exec_clocks_o)
      run(8'ha3, 1'b0, n);
      `CHK("mid pointer inc", 16'h0001, data_pointer_16bit_o)
      $display("test mid reset done");
   endtask
   initial begin
      repeat (2) @(negedge clk_i);
      sys_rst_i = 0;
      t_reset;
      t_alu;
      t_ptr;
      t_timing;
      t_xmov;
      t_mid_reset;
      stop_test;
   end
   // about 60 cycles expected, so a few times that is generous
   initial begin
      #2000;
      miscompares++;
      stop_test;
   end
endmodule
`default_nettype wire
